// ### common/evcount_pkg.sv
// Shared constants and types for the event counter bank.
package evcount_pkg;
    // ==========================================================
    // Sizes
    localparam int N_CNT = 4;
    localparam int N_TMR = 2;
    localparam int N_LINE = 4;
    localparam int N_ACT = 2;
    localparam int N_MS = 10;
    localparam int CW = 32;
    localparam int SRC_W = 5;
    localparam int N_EVT = N_CNT + N_TMR;
    // ==========================================================
    // Source codes of count_increment_origin
    localparam logic [SRC_W-1:0] SRC_OFF = 5'h00;
    localparam logic [SRC_W-1:0] SRC_TICK = 5'h0B;
    localparam logic [SRC_W-1:0] SRC_LINE0 = 5'h0C;
    localparam logic [SRC_W-1:0] SRC_CEND1 = 5'h10;
    localparam logic [SRC_W-1:0] SRC_TEND1 = 5'h14;
    localparam logic [SRC_W-1:0] SRC_ACT1 = 5'h16;
    localparam logic [SRC_W-1:0] SRC_LEG0 = 5'h18;
    // ==========================================================
    // Edge modes of count_edge_mode
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_ANY = 2'h2;
    // ==========================================================
    // Register byte offsets
    localparam logic [5:0] OFS_SEL = 6'h00;
    localparam logic [5:0] OFS_SRC = 6'h04;
    localparam logic [5:0] OFS_EDGE = 6'h08;
    localparam logic [5:0] OFS_VALUE = 6'h0C;
    localparam logic [5:0] OFS_SNAP = 6'h10;
    localparam logic [5:0] OFS_CMD = 6'h14;
    localparam logic [5:0] OFS_MAX = 6'h18;
    localparam logic [5:0] OFS_EVEN = 6'h1C;
    localparam logic [5:0] OFS_STAT = 6'h20;
    localparam logic [5:0] OFS_TSEL = 6'h24;
    localparam logic [5:0] OFS_TCTRL = 6'h28;
    localparam logic [5:0] OFS_TDELAY = 6'h2C;
    localparam logic [5:0] OFS_TDUR = 6'h30;
    localparam logic [5:0] OFS_TVAL = 6'h34;
    // ==========================================================
    // Field positions and reset values
    localparam int CMD_CLR_BIT = 0;
    localparam int TC_MEAS_BIT = 4;
    localparam logic [2:0] SEL_RST = 3'h1;
    localparam logic [CW-1:0] MAX_RST = 32'h0000_0000;
    localparam logic [CW-1:0] TDUR_RST = 32'h0000_0001;
    // ==========================================================
    // Time base
    localparam int CLK_PERIOD_NS = 8;
    localparam int TICK_PERIOD_NS = 1000;
    localparam int TICK_CYC = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);
    // ==========================================================
    // Timer states, Gray along idle-delay-pulse
    typedef enum logic [1:0] {
        T_IDLE = 2'b00,
        T_DELAY = 2'b01,
        T_PULSE = 2'b11,
        T_MEAS = 2'b10
    } tmr_state_t;
endpackage

// ### design/pulse_timer.sv
// One strobe and duration timer.
`timescale 1ns/1ps
module pulse_timer import evcount_pkg::*; (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic trig_rise,
    input wire logic level,
    input wire logic measure,
    input wire logic [CW-1:0] delay,
    input wire logic [CW-1:0] duration,
    output logic active,
    output logic done,
    output logic [CW-1:0] value
);
    tmr_state_t state;
    logic delay_last;
    logic pulse_last;

    assign delay_last = (value == delay - 32'h1);
    assign pulse_last = (duration == '0) || (value == duration - 32'h1);
    assign active = (state == T_PULSE) || (state == T_MEAS);

    // ==========================================================
    // Sequencer
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state <= T_IDLE;
            value <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state)
                T_IDLE: begin
                    if (trig_rise) begin
                        if (measure) begin
                            // The cycle that shows the rise is already a high cycle.
                            value <= 32'h1;
                            state <= T_MEAS;
                        end else if (delay == '0) begin
                            value <= '0;
                            state <= T_PULSE;
                        end else begin
                            value <= '0;
                            state <= T_DELAY;
                        end
                    end
                end
                T_DELAY: begin
                    if (delay_last) begin
                        value <= '0;
                        state <= T_PULSE;
                    end else begin
                        value <= value + 32'h1;
                    end
                end
                T_PULSE: begin
                    value <= value + 32'h1;
                    if (pulse_last) begin
                        done <= 1'b1;
                        state <= T_IDLE;
                    end
                end
                T_MEAS: begin
                    if (level) begin
                        value <= value + 32'h1;
                    end else begin
                        done <= 1'b1;
                        state <= T_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// ### design/event_counter_bank.sv
// Bank of selectable-source event counters with timers and a register slave.
//
// The register offsets and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
module event_counter_bank import evcount_pkg::*; (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic capture_sequence_trigger,
    input wire logic capture_sequence_begin,
    input wire logic capture_sequence_finish,
    input wire logic image_trigger,
    input wire logic image_begin,
    input wire logic image_finish,
    input wire logic scan_row_begin,
    input wire logic scan_row_finish,
    input wire logic integration_begin,
    input wire logic integration_finish,
    input wire logic [N_LINE-1:0] io_line,
    input wire logic [N_ACT-1:0] broadcast_signal,
    output logic [N_CNT-1:0] chained_count_done,
    output logic [N_TMR-1:0] timer_pulse_done,
    output logic [N_TMR-1:0] timer_active,
    output logic [N_EVT-1:0] notification
);
    // ==========================================================
    // Decoding
    function automatic logic [7:0] one_hot(input logic [2:0] idx);
        one_hot = (idx == 3'h0) ? 8'h00 : 8'h01 << (idx - 3'h1);
    endfunction

    function automatic logic pick_edge(input logic [1:0] mode, input logic r,
                                       input logic f);
        case (mode)
            EDGE_RISE: pick_edge = r;
            EDGE_FALL: pick_edge = f;
            EDGE_ANY: pick_edge = r | f;
            default: pick_edge = 1'b0;
        endcase
    endfunction

    logic ack;
    logic bus_wr;
    logic [2:0] cnt_sel;
    logic [1:0] tmr_sel;
    logic [7:0] sel_hot;
    logic [7:0] tsel_hot;
    logic [1:0] sel_idx;
    logic tsel_idx;
    logic [N_EVT-1:0] evt_en;
    logic [N_MS-1:0] ms_q;
    logic [N_LINE-1:0] line_q;
    logic [N_ACT-1:0] act_q;
    logic [7:0] tick_cnt;
    logic tick;
    logic [31:0] src_now;
    logic [31:0] src_prev;
    logic [31:0] rise;
    logic [31:0] fall;
    logic [SRC_W-1:0] src_sel [N_CNT];
    logic [1:0] edge_mode [N_CNT];
    logic [CW-1:0] cnt [N_CNT];
    logic [CW-1:0] snap [N_CNT];
    logic [CW-1:0] cnt_max [N_CNT];
    logic [N_CNT-1:0] inc;
    logic [N_CNT-1:0] clr;
    logic [N_CNT-1:0] wr_val;
    logic [7:0] tctrl [N_TMR];
    logic [CW-1:0] tdelay [N_TMR];
    logic [CW-1:0] tdur [N_TMR];
    logic [CW-1:0] tval [N_TMR];
    logic [31:0] next_readdata;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    // ==========================================================
    // Bus slave: one wait cycle, then the answer.
    assign waitrequest = (read | write) & ~ack;
    assign bus_wr = write & ack;
    assign sel_hot = one_hot(cnt_sel);
    assign tsel_hot = one_hot({1'b0, tmr_sel});
    assign sel_idx = 2'(cnt_sel - 3'h1);
    assign tsel_idx = tmr_sel[1] ^ tmr_sel[0] ? ~tmr_sel[0] : 1'b0;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ack <= 1'b0;
        end else begin
            ack <= (read | write) & ~ack;
        end
    end

    always_comb begin
        next_readdata = 32'h0000_0000;
        case (address)
            OFS_SEL: next_readdata = {29'h0, cnt_sel};
            OFS_SRC: next_readdata = {27'h0, src_sel[sel_idx]};
            OFS_EDGE: next_readdata = {30'h0, edge_mode[sel_idx]};
            OFS_VALUE: next_readdata = cnt[sel_idx];
            OFS_SNAP: next_readdata = snap[sel_idx];
            OFS_MAX: next_readdata = cnt_max[sel_idx];
            OFS_EVEN: next_readdata = {26'h0, evt_en};
            OFS_STAT: next_readdata = {26'h0, timer_active, N_CNT'(0)};
            OFS_TSEL: next_readdata = {30'h0, tmr_sel};
            OFS_TCTRL: next_readdata = {24'h0, tctrl[tsel_idx]};
            OFS_TDELAY: next_readdata = tdelay[tsel_idx];
            OFS_TDUR: next_readdata = tdur[tsel_idx];
            OFS_TVAL: next_readdata = tval[tsel_idx];
            default: next_readdata = 32'h0000_0000;
        endcase
        if (address == OFS_STAT) begin
            for (int k = 0; k < N_CNT; k++) begin
                next_readdata[k] = (src_sel[k] != SRC_OFF);
            end
        end
        if ((address inside {OFS_SRC, OFS_EDGE, OFS_VALUE, OFS_SNAP, OFS_MAX})
            && (sel_hot[N_CNT-1:0] == '0)) begin
            next_readdata = 32'h0000_0000;
        end
        if ((address inside {OFS_TCTRL, OFS_TDELAY, OFS_TDUR, OFS_TVAL})
            && (tsel_hot[N_TMR-1:0] == '0)) begin
            next_readdata = 32'h0000_0000;
        end
    end

    // Read data is loaded while waiting, so it stands when waitrequest drops.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            readdata <= 32'h0000_0000;
        end else if (read & ~ack) begin
            readdata <= next_readdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_sel <= SEL_RST;
            tmr_sel <= 2'(SEL_RST);
            evt_en <= '0;
        end else if (bus_wr) begin
            if (address == OFS_SEL) begin
                cnt_sel <= writedata[2:0];
            end
            if (address == OFS_TSEL) begin
                tmr_sel <= writedata[1:0];
            end
            if (address == OFS_EVEN) begin
                evt_en <= writedata[N_EVT-1:0];
            end
        end
    end

    // ==========================================================
    // Event sources
    // One register stage aligns the inputs to ref_clk.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ms_q <= '0;
            line_q <= '0;
            act_q <= '0;
            src_prev <= '0;
        end else begin
            ms_q <= {integration_finish, integration_begin, scan_row_finish,
                     scan_row_begin, image_finish, image_begin, image_trigger,
                     capture_sequence_finish, capture_sequence_begin,
                     capture_sequence_trigger};
            line_q <= io_line;
            act_q <= broadcast_signal;
            src_prev <= src_now;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (tick_cnt == TICK_LAST);
            tick_cnt <= (tick_cnt == TICK_LAST) ? 8'h00 : tick_cnt + 8'h01;
        end
    end

    // Bit zero is the off code; counter and timer ends sit here.
    assign src_now = {4'h0, line_q, act_q, timer_pulse_done, chained_count_done,
                      line_q, tick, ms_q, 1'b0};
    assign rise = src_now & ~src_prev;
    assign fall = ~src_now & src_prev;

    // ==========================================================
    // Counters
    for (genvar i = 0; i < N_CNT; i++) begin : g_cnt
        logic legacy;
        assign legacy = (src_sel[i] >= SRC_LEG0);
        assign clr[i] = bus_wr && (address == OFS_CMD) && writedata[CMD_CLR_BIT]
                        && sel_hot[i];
        assign wr_val[i] = bus_wr && (address == OFS_VALUE) && sel_hot[i];
        // Legacy codes force rising edges; others follow edge mode.
        assign inc[i] = legacy ? rise[src_sel[i]]
                               : pick_edge(edge_mode[i], rise[src_sel[i]],
                                           fall[src_sel[i]]);

        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                src_sel[i] <= SRC_OFF;
                edge_mode[i] <= EDGE_RISE;
                cnt_max[i] <= MAX_RST;
            end else if (bus_wr && sel_hot[i]) begin
                if (address == OFS_SRC) begin
                    src_sel[i] <= writedata[SRC_W-1:0];
                end
                if (address == OFS_EDGE) begin
                    edge_mode[i] <= writedata[1:0];
                end
                if (address == OFS_MAX) begin
                    cnt_max[i] <= writedata;
                end
            end
        end

        // Clear beats write, write beats an event.
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                cnt[i] <= '0;
                snap[i] <= '0;
                chained_count_done[i] <= 1'b0;
            end else begin
                chained_count_done[i] <= 1'b0;
                if (clr[i]) begin
                    snap[i] <= cnt[i];
                    cnt[i] <= '0;
                end else if (wr_val[i]) begin
                    cnt[i] <= writedata;
                end else if (inc[i]) begin
                    // End of count wraps and pulses.
                    if (cnt[i] + 32'h1 == cnt_max[i]) begin
                        cnt[i] <= '0;
                        chained_count_done[i] <= 1'b1;
                    end else begin
                        cnt[i] <= cnt[i] + 32'h1;
                    end
                end
            end
        end

        a_clear_zeroes: assert property (clr[i] |=> cnt[i] == '0)
            else $error("counter not zero after clear");
        a_snap_latch: assert property (clr[i] |=> snap[i] == $past(cnt[i]))
            else $error("snapshot does not hold value before clear");
        a_off_holds: assert property (src_sel[i] == SRC_OFF && !clr[i] && !wr_val[i]
                                      |=> $stable(cnt[i]))
            else $error("counter moved with source off");
        a_inc_by_one: assert property (inc[i] && !clr[i] && !wr_val[i]
                                       && cnt[i] + 32'h1 != cnt_max[i]
                                       |=> cnt[i] == $past(cnt[i]) + 32'h1)
            else $error("event did not add exactly one");
        a_write_loads: assert property (wr_val[i] && !clr[i]
                                        |=> cnt[i] == $past(writedata))
            else $error("written count not loaded");
        // End pulse leaves a zero count.
        a_end_wraps: assert property (inc[i] && !clr[i] && !wr_val[i]
                                      && cnt[i] + 32'h1 == cnt_max[i]
                                      |=> chained_count_done[i] && cnt[i] == '0)
            else $error("count end did not wrap and pulse");
        // Legacy codes never count a falling edge.
        a_legacy_rise: assert property (legacy && inc[i] |-> rise[src_sel[i]])
            else $error("legacy source counted a non-rising edge");
    end

    // ==========================================================
    // Timers
    for (genvar t = 0; t < N_TMR; t++) begin : g_tmr
        always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
                tctrl[t] <= 8'h00;
                tdelay[t] <= '0;
                tdur[t] <= TDUR_RST;
            end else if (bus_wr && tsel_hot[t]) begin
                if (address == OFS_TCTRL) begin
                    tctrl[t] <= writedata[7:0];
                end
                if (address == OFS_TDELAY) begin
                    tdelay[t] <= writedata;
                end
                if (address == OFS_TDUR) begin
                    tdur[t] <= writedata;
                end
            end
        end

        // Triggered by the rising edge of the chosen line.
        pulse_timer u_timer (
            .ref_clk(ref_clk),
            .rstn(rstn),
            .trig_rise(rise[SRC_LINE0 + tctrl[t][1:0]]),
            .level(line_q[tctrl[t][1:0]]),
            .measure(tctrl[t][TC_MEAS_BIT]),
            .delay(tdelay[t]),
            .duration(tdur[t]),
            .active(timer_active[t]),
            .done(timer_pulse_done[t]),
            .value(tval[t])
        );
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            notification <= '0;
        end else begin
            notification <= {timer_pulse_done, chained_count_done} & evt_en;
        end
    end

    // Every request is answered after one wait cycle.
    a_bus_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus request not answered in one wait cycle");
    // Ticks are spaced by the divider.
    a_tick_spacing: assert property (tick |=> !tick [*8])
        else $error("time base ticks too close");
    a_notify_cause: assert property (notification[0] |-> $past(chained_count_done[0]))
        else $error("notification without counter end");

    c_cascade: cover property (chained_count_done[0] ##[1:3] inc[1]);
    c_clear_busy: cover property (inc[0] ##1 clr[0]);
    c_timer_done: cover property (timer_active[0] ##1 timer_pulse_done[0]);
endmodule

// ### bench/event_source_model.sv
// Far-side model that pulses the device's event inputs on request.
`timescale 1ns/1ps
module event_source_model import evcount_pkg::*; (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic kick,
    input wire logic [SRC_W-1:0] code,
    output logic [9:0] ev,
    output logic [N_LINE-1:0] io_line,
    output logic [N_ACT-1:0] broadcast_signal
);
    // ==========================================================
    // Pulses
    // One-cycle pulses return low at once, so every pulse gives a rise and a fall.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ev <= '0;
            io_line <= '0;
            broadcast_signal <= '0;
        end else begin
            ev <= '0;
            io_line <= '0;
            broadcast_signal <= '0;
            if (kick && code >= 5'h01 && code <= 5'h0A) begin
                ev[code - 5'h01] <= 1'b1;
            end
            if (kick && (code[4:2] == 3'h3 || code[4:2] == 3'h6)) begin
                io_line[code[1:0]] <= 1'b1;
            end
            if (kick && code[4:1] == 4'hB) begin
                broadcast_signal[code[0]] <= 1'b1;
            end
        end
    end
endmodule

// ### bench/tb.sv
// Self-checking bench for the event counter bank.
`timescale 1ns/1ps
module tb import evcount_pkg::*;;
    logic ref_clk = 1'b0, rstn = 1'b0, read = 1'b0, write = 1'b0, kick = 1'b0, waitrequest;
    logic [5:0] address = 6'h00;
    logic [31:0] writedata = 32'h0, readdata, rd, v;
    logic [SRC_W-1:0] code = 5'h00;
    logic [1:0] m;
    logic [9:0] ev;
    logic [N_LINE-1:0] io_line;
    logic [N_ACT-1:0] broadcast_signal;
    logic [N_CNT-1:0] chained_count_done;
    logic [N_TMR-1:0] timer_pulse_done, timer_active;
    logic [N_EVT-1:0] notification;
    int n_mismatch = 0, samples_checked = 0, act_cyc = 0, chain_cnt = 0, note_cnt = 0, n;
    always #4 ref_clk = ~ref_clk;
    event_counter_bank dut (.ref_clk(ref_clk), .rstn(rstn), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .capture_sequence_trigger(ev[0]), .capture_sequence_begin(ev[1]),
        .capture_sequence_finish(ev[2]), .image_trigger(ev[3]), .image_begin(ev[4]),
        .image_finish(ev[5]), .scan_row_begin(ev[6]), .scan_row_finish(ev[7]),
        .integration_begin(ev[8]), .integration_finish(ev[9]), .io_line(io_line),
        .broadcast_signal(broadcast_signal), .chained_count_done(chained_count_done),
        .timer_pulse_done(timer_pulse_done), .timer_active(timer_active),
        .notification(notification));
    event_source_model far (.ref_clk(ref_clk), .rstn(rstn), .kick(kick), .code(code), .ev(ev),
        .io_line(io_line), .broadcast_signal(broadcast_signal));
    always @(posedge ref_clk) begin
        if (timer_active[0] === 1'b1) act_cyc++;
        if (chained_count_done[0] === 1'b1) chain_cnt++;
        if (notification[0] === 1'b1) note_cnt++;
    end
    // ==========================================================
    // Tasks
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [5:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        write <= 1'b1;
        @(posedge ref_clk iff !waitrequest);
        write <= 1'b0;
        @(posedge ref_clk);
    endtask
    task rdr(input logic [5:0] a);
        address <= a;
        read <= 1'b1;
        @(posedge ref_clk iff !waitrequest);
        rd = readdata;
        read <= 1'b0;
        @(posedge ref_clk);
    endtask
    task setup(input int i, input logic [SRC_W-1:0] s, input logic [1:0] e);
        wr(OFS_SEL, 32'(i));
        wr(OFS_SRC, {27'h0, s});
        wr(OFS_EDGE, {30'h0, e});
        wr(OFS_VALUE, 32'h0);
    endtask
    // The gap after each pulse covers the two-cycle input latency.
    task fire(input logic [SRC_W-1:0] c, input int k);
        repeat (k) begin
            code <= c;
            kick <= 1'b1;
            @(posedge ref_clk);
            kick <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
    endtask
    // Legacy line codes count rises only; edge mode three counts nothing.
    function automatic logic [31:0] exp_count(logic [1:0] e, logic [SRC_W-1:0] c, int k);
        return 32'((c >= SRC_LEG0) ? k : (e == EDGE_ANY) ? 2 * k : (e == 2'h3) ? 0 : k);
    endfunction
    task end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // Tests
    initial begin
        #160000;
        n_mismatch++;
        end_of_test;
    end
    initial begin
        n = $urandom(26132);
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        rdr(OFS_SEL); check(rd, {29'h0, SEL_RST});
        rdr(OFS_MAX); check(rd, MAX_RST);
        rdr(OFS_STAT); check(rd, 32'h0);
        rdr(OFS_TDUR); check(rd, TDUR_RST);
        rdr(6'h3C); check(rd, 32'h0);
        $display("reset test done");
        for (int c = 1; c < 28; c++) begin
            if (c == 11 || (c > 15 && c < 22)) continue;
            m = 2'($urandom_range(3, 0));
            n = $urandom_range(4, 1);
            setup($urandom_range(4, 1), 5'(c), m);
            fire(5'(c), n);
            rdr(OFS_VALUE); check(rd, exp_count(m, 5'(c), n));
        end
        $display("source test done");
        setup(2, SRC_OFF, EDGE_RISE);
        wr(OFS_VALUE, 32'h5);
        fire(5'h01, 2);
        rdr(OFS_VALUE); check(rd, 32'h5);
        v = $urandom;
        setup(3, SRC_LINE0, EDGE_RISE);
        wr(OFS_VALUE, v);
        fire(SRC_LINE0, 1);
        rdr(OFS_VALUE); check(rd, v + 32'h1);
        wr(OFS_CMD, 32'h1);
        rdr(OFS_SNAP); check(rd, v + 32'h1);
        rdr(OFS_VALUE); check(rd, 32'h0);
        $display("write and clear test done");
        setup(1, 5'h0E, EDGE_RISE);
        wr(OFS_MAX, 32'h2);
        wr(OFS_EVEN, 32'h1);
        setup(2, SRC_CEND1, EDGE_RISE);
        chain_cnt = 0;
        note_cnt = 0;
        fire(5'h0E, 5);
        rdr(OFS_VALUE); check(rd, 32'h2);
        check(32'(chain_cnt), 32'h2);
        check(32'(note_cnt), 32'h2);
        setup(4, SRC_TICK, EDGE_RISE);
        repeat (3 * TICK_CYC) @(posedge ref_clk);
        rdr(OFS_VALUE); check({31'h0, rd == 32'h3 || rd == 32'h4}, 32'h1);
        $display("cascade and tick test done");
        setup(3, SRC_TEND1, EDGE_RISE);
        wr(OFS_TCTRL, 32'h1);
        wr(OFS_TDELAY, 32'h3);
        wr(OFS_TDUR, 32'h5);
        act_cyc = 0;
        fire(5'h0D, 1);
        repeat (12) @(posedge ref_clk);
        rdr(OFS_VALUE); check(rd, 32'h1);
        check(32'(act_cyc), 32'h5);
        wr(OFS_TCTRL, 32'h11);
        fire(5'h0D, 1);
        rdr(OFS_TVAL); check(rd, 32'h1);
        $display("timer test done");
        wr(OFS_SEL, 32'h5);
        wr(OFS_VALUE, v);
        rdr(OFS_SEL); check(rd, 32'h5);
        rdr(OFS_VALUE); check(rd, 32'h0);
        wr(OFS_SEL, 32'h1);
        rdr(OFS_VALUE); check(rd, 32'h1);
        $display("index range test done");
        end_of_test;
    end
endmodule
